// File: ose_pkg.sv
package ose_pkg;

  // Word and order geometry.
  localparam int WORD_W = 40;
  localparam int ADDR_W = 12;
  localparam int OP_W   = 8;

  // Order codes handled by this block.
  localparam logic [7:0] OP_MID_STORE     = 8'h46;
  localparam logic [7:0] OP_CLR_MID_STORE = 8'h47;
  localparam logic [7:0] OP_LOW_STORE     = 8'h42;
  localparam logic [7:0] OP_CLR_LOW_STORE = 8'h43;
  localparam logic [7:0] OP_IO            = 8'h80;
  localparam logic [7:0] OP_HALT_XFER     = 8'h30;
  localparam logic [7:0] OP_PLAIN_HALT    = 8'h20;
  localparam logic [7:0] OP_SLS           = 8'hf0;
  localparam logic [7:0] OP_CLR_SLS       = 8'hf1;
  localparam logic [7:0] OP_SEED_SLS      = 8'hf9;
  localparam logic [7:0] OP_SJ            = 8'ha0;
  localparam logic [7:0] OP_CLR_SJ        = 8'ha1;
  localparam logic [7:0] OP_SEED_SJ       = 8'ha9;

  // Address field that selects printing or tape reading under OP_IO.
  localparam logic [11:0] IO_PRINT_ADDR = 12'h828;
  localparam logic [11:0] IO_READ_ADDR  = 12'h028;

  // Field masks; vector bit 39 is the sign digit, bit 0 the 2^-39 digit.
  localparam logic [39:0] MID_FIELD_MASK = 40'h00_3ff0_0000;
  localparam logic [39:0] LOW_FIELD_MASK = 40'h00_0000_03ff;
  localparam logic [39:0] SEED_VALUE     = 40'h40_0000_0000;

  // Reset values.
  localparam logic [39:0] WORD_RESET  = 40'h00_0000_0000;
  localparam logic [11:0] ADDR_RESET  = 12'h000;
  localparam logic [19:0] ORDER_RESET = 20'h0_0000;

  // Print buffer geometry.
  localparam int PRINT_FIFO_DEPTH = 16;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [11:0] address;
  } ose_order_type;

  typedef struct packed {
    logic        write;
    logic [11:0] address;
    logic [39:0] data;
  } ose_mem_req_type;

  typedef struct packed {
    logic [39:0] accumulator;
    logic [39:0] quotient;
    logic        right_shift;
    logic        jump;
    logic        jump_right;
    logic [11:0] jump_address;
  } ose_foreign_result_type;

endpackage

// File: ose_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module ose_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] storage [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;

  assign o_ready = count != (PTR_W+1)'(DEPTH);
  assign o_valid = count != '0;
  assign o_data  = storage[rd_ptr];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  // Storage has no reset so it maps onto plain registers.
  always_ff @(posedge i_clk) begin
    if (push) storage[wr_ptr] <= i_data;
  end

endmodule

`default_nettype wire

// File: ose_core.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RL1 - Order 47 clears the accumulator, then stores its middle digits into word x.
// RL2 - Order 46 replaces digits 2^-10..2^-19 of word x; accumulator unchanged.
// RL3 - Order 42 replaces digits 2^-30..2^-39 of word x; accumulator unchanged.
// RL4 - Order 43 clears the accumulator, then does the low-field store.
// RL5 - Order 80828 sends the quotient register word to the printer.
// RL6 - Order 80028 reads one tape word into the accumulator.
// RL7 - Order 30 halts; as right-hand order, restart at left order of x.
// RL8 - Order 30 as left-hand order: restart runs right order, then jumps to x.
// RL9 - With the panel bypass switch set, order 30 is a plain transfer to x.
// RL10 - Single left shift moves both registers up, feeding the saved bit in.
// RL11 - Right-shifting orders save quotient digit 39 for the next single left shift.
// RL12 - Order F1 clears the accumulator, then does the single left shift.
// RL13 - Seeded shift clears the accumulator, inserts 2^-1, then shifts left.
// RL14 - Shift-and-jump shifts, then jumps to x after the right-hand order.
// RL15 - Order K18 clears the accumulator, then does shift-and-jump.
// RL16 - Seeded shift-and-jump inserts 2^-1 in the accumulator, then shift-and-jump.
// RL17 - Programs use rounded division only when divisor exceeds dividend in size.
// RL18 - Each word runs its left order, then right order, unless control transfers.
module ose_core (
  // Clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_reset_n,
  // Operator panel pins
  input  wire logic                           i_start_pin,
  input  wire logic                           i_bypass_pin,
  output logic                                o_halted,
  output logic [11:0]                         o_location,
  output logic                                o_right_half,
  // Memory port
  output logic                                o_mem_req,
  output ose_pkg::ose_mem_req_type            o_mem,
  input  wire logic                           i_mem_ack,
  input  wire logic [39:0]                    i_mem_rdata,
  // Input tape
  input  wire logic                           i_tape_valid,
  input  wire logic [39:0]                    i_tape_data,
  output logic                                o_tape_ready,
  // Printer
  output logic                                o_print_valid,
  input  wire logic                           i_print_ready,
  output logic [39:0]                         o_print_data,
  // Orders outside this subset
  output logic                                o_foreign_valid,
  output ose_pkg::ose_order_type              o_foreign_order,
  output logic [39:0]                         o_accumulator,
  output logic [39:0]                         o_quotient,
  input  wire logic                           i_foreign_done,
  input  wire ose_pkg::ose_foreign_result_type i_foreign_result
);

  typedef enum logic [2:0] {
    ST_HALTED,
    ST_FETCH,
    ST_EXECUTE,
    ST_STORE_READ,
    ST_STORE_WRITE,
    ST_PRINT,
    ST_TAPE,
    ST_FOREIGN
  } ose_state_type;

  ose_state_type state;
  ose_state_type next_state;

  logic [39:0] accumulator_register;
  logic [39:0] quotient_register;
  logic        saved_bit;
  logic [11:0] pc;
  logic        right_half;
  logic [39:0] word_buf;
  logic        pending_jump;
  logic [11:0] pending_addr;
  logic        resume_fetch;
  logic        store_low;
  logic [11:0] mem_addr;
  logic [39:0] mem_wdata;
  ose_pkg::ose_order_type foreign_order;

  logic [39:0] next_accumulator;
  logic [39:0] next_quotient;
  logic        next_saved_bit;
  logic [11:0] next_pc;
  logic        next_right_half;
  logic [39:0] next_word_buf;
  logic        next_pending_jump;
  logic [11:0] next_pending_addr;
  logic        next_resume_fetch;
  logic        next_store_low;
  logic [11:0] next_mem_addr;
  logic [39:0] next_mem_wdata;
  ose_pkg::ose_order_type next_foreign_order;
  logic        go_next;
  logic        halt_after;

  // Panel synchronisers; the first stage feeds only the second.
  logic [1:0] start_sync;
  logic [1:0] bypass_sync;
  logic       start_seen;
  wire        start_pulse = start_sync[1] && !start_seen;
  wire        bypass_set  = bypass_sync[1];

  // Order decode.
  ose_pkg::ose_order_type cur;
  assign cur = right_half ? ose_pkg::ose_order_type'(word_buf[19:0])
                          : ose_pkg::ose_order_type'(word_buf[39:20]);
  wire [7:0] op = cur.opcode;
  wire is_mid_store   = op == ose_pkg::OP_MID_STORE || op == ose_pkg::OP_CLR_MID_STORE;
  wire is_low_store   = op == ose_pkg::OP_LOW_STORE || op == ose_pkg::OP_CLR_LOW_STORE;
  wire is_store_clear = op == ose_pkg::OP_CLR_MID_STORE || op == ose_pkg::OP_CLR_LOW_STORE;
  wire is_print       = op == ose_pkg::OP_IO && cur.address == ose_pkg::IO_PRINT_ADDR;
  wire is_read        = op == ose_pkg::OP_IO && cur.address == ose_pkg::IO_READ_ADDR;
  wire is_halt_xfer   = op == ose_pkg::OP_HALT_XFER;
  wire is_plain_halt  = op == ose_pkg::OP_PLAIN_HALT;
  wire shift_clear    = op == ose_pkg::OP_CLR_SLS || op == ose_pkg::OP_CLR_SJ;
  wire shift_seed     = op == ose_pkg::OP_SEED_SLS || op == ose_pkg::OP_SEED_SJ;
  wire shift_jump     = op == ose_pkg::OP_SJ || shift_clear && op[7:4] == 4'ha || op == ose_pkg::OP_SEED_SJ;
  wire is_shift       = op == ose_pkg::OP_SLS || op == ose_pkg::OP_CLR_SLS || op == ose_pkg::OP_SEED_SLS
                        || op == ose_pkg::OP_SJ || op == ose_pkg::OP_CLR_SJ || op == ose_pkg::OP_SEED_SJ;

  // Clear or seed the accumulator before the shift.
  // RL12 clear before shift
  // RL13 seed with half
  wire [39:0] shift_base = shift_clear ? ose_pkg::WORD_RESET
                         : shift_seed  ? ose_pkg::SEED_VALUE : accumulator_register;
  // RL10 double register shift
  wire [39:0] shifted_acc = {shift_base[38:0], quotient_register[38]};
  wire [39:0] shifted_quo = {quotient_register[39], quotient_register[37:0], saved_bit};

  // RL2 middle field mask
  // RL3 low field mask
  wire [39:0] store_mask = store_low ? ose_pkg::LOW_FIELD_MASK : ose_pkg::MID_FIELD_MASK;
  wire [39:0] merged     = (i_mem_rdata & ~store_mask) | (accumulator_register & store_mask);

  // Print buffer.
  logic fifo_in_ready;
  wire  fifo_push = state == ST_PRINT;

  ose_fifo #(
    .WIDTH (ose_pkg::WORD_W),
    .DEPTH (ose_pkg::PRINT_FIFO_DEPTH)
  ) u_print_fifo (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_valid   (fifo_push),
    .o_ready   (fifo_in_ready),
    .i_data    (quotient_register),
    .o_valid   (o_print_valid),
    .i_ready   (i_print_ready),
    .o_data    (o_print_data)
  );

  always_comb begin
    next_state         = state;
    next_accumulator   = accumulator_register;
    next_quotient      = quotient_register;
    next_saved_bit     = saved_bit;
    next_pc            = pc;
    next_right_half    = right_half;
    next_word_buf      = word_buf;
    next_pending_jump  = pending_jump;
    next_pending_addr  = pending_addr;
    next_resume_fetch  = resume_fetch;
    next_store_low     = store_low;
    next_mem_addr      = mem_addr;
    next_mem_wdata     = mem_wdata;
    next_foreign_order = foreign_order;
    go_next            = 1'b0;
    halt_after         = 1'b0;
    unique case (state)
      ST_HALTED: begin
        if (start_pulse) next_state = resume_fetch ? ST_FETCH : ST_EXECUTE;
      end
      ST_FETCH: begin
        if (i_mem_ack) begin
          next_word_buf = i_mem_rdata;
          next_state    = ST_EXECUTE;
        end
      end
      ST_EXECUTE: begin
        if (is_mid_store || is_low_store) begin
          // RL1 clear then store
          // RL4 clear then store
          if (is_store_clear) next_accumulator = ose_pkg::WORD_RESET;
          next_store_low = is_low_store;
          next_mem_addr  = cur.address;
          next_state     = ST_STORE_READ;
        end else if (is_print) begin
          next_state = ST_PRINT;
        end else if (is_read) begin
          next_state = ST_TAPE;
        end else if (is_halt_xfer) begin
          if (bypass_set) begin
            // RL9 bypass as transfer
            next_pc           = cur.address;
            next_right_half   = 1'b0;
            next_pending_jump = 1'b0;
            next_state        = ST_FETCH;
          end else if (right_half) begin
            // RL7 resume at x
            next_pc           = cur.address;
            next_right_half   = 1'b0;
            next_pending_jump = 1'b0;
            next_resume_fetch = 1'b1;
            next_state        = ST_HALTED;
          end else begin
            // RL8 right order first
            next_right_half   = 1'b1;
            next_pending_jump = 1'b1;
            next_pending_addr = cur.address;
            next_resume_fetch = 1'b0;
            next_state        = ST_HALTED;
          end
        end else if (is_plain_halt) begin
          go_next    = 1'b1;
          halt_after = 1'b1;
        end else if (is_shift) begin
          next_accumulator = shifted_acc;
          next_quotient    = shifted_quo;
          if (shift_jump) begin
            // RL14 jump after right order
            // RL15 cleared variant
            // RL16 seeded variant
            next_pending_jump = 1'b1;
            next_pending_addr = cur.address;
          end
          go_next = 1'b1;
        end else begin
          next_foreign_order = cur;
          next_state         = ST_FOREIGN;
        end
      end
      ST_STORE_READ: begin
        if (i_mem_ack) begin
          next_mem_wdata = merged;
          next_state     = ST_STORE_WRITE;
        end
      end
      ST_STORE_WRITE: begin
        go_next = i_mem_ack;
      end
      ST_PRINT: begin
        // RL5 quotient to printer
        go_next = fifo_in_ready;
      end
      ST_TAPE: begin
        // RL6 tape into accumulator
        if (i_tape_valid) next_accumulator = i_tape_data;
        go_next = i_tape_valid;
      end
      ST_FOREIGN: begin
        if (i_foreign_done) begin
          next_accumulator = i_foreign_result.accumulator;
          next_quotient    = i_foreign_result.quotient;
          // RL11 save quotient digit
          if (i_foreign_result.right_shift) next_saved_bit = quotient_register[0];
          if (i_foreign_result.jump) begin
            next_pc           = i_foreign_result.jump_address;
            next_right_half   = i_foreign_result.jump_right;
            next_pending_jump = 1'b0;
            next_state        = ST_FETCH;
          end else begin
            go_next = 1'b1;
          end
        end
      end
    endcase
    // RL18 left then right
    if (go_next) begin
      if (!right_half) begin
        next_right_half   = 1'b1;
        next_resume_fetch = 1'b0;
        next_state        = halt_after ? ST_HALTED : ST_EXECUTE;
      end else begin
        next_right_half   = 1'b0;
        next_resume_fetch = 1'b1;
        next_pc           = next_pending_jump ? next_pending_addr : 12'(pc + 12'h001);
        next_pending_jump = 1'b0;
        next_state        = halt_after ? ST_HALTED : ST_FETCH;
      end
    end
    if (next_state == ST_FETCH) next_mem_addr = next_pc;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_sync  <= 2'h0;
      bypass_sync <= 2'h0;
      start_seen  <= 1'b0;
    end else begin
      start_sync  <= {start_sync[0], i_start_pin};
      bypass_sync <= {bypass_sync[0], i_bypass_pin};
      start_seen  <= start_sync[1];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state                <= ST_HALTED;
      accumulator_register <= ose_pkg::WORD_RESET;
      quotient_register    <= ose_pkg::WORD_RESET;
      saved_bit            <= 1'b0;
      pc                   <= ose_pkg::ADDR_RESET;
      right_half           <= 1'b0;
      word_buf             <= ose_pkg::WORD_RESET;
      pending_jump         <= 1'b0;
      pending_addr         <= ose_pkg::ADDR_RESET;
      resume_fetch         <= 1'b1;
      store_low            <= 1'b0;
      mem_addr             <= ose_pkg::ADDR_RESET;
      mem_wdata            <= ose_pkg::WORD_RESET;
      foreign_order        <= ose_pkg::ORDER_RESET;
    end else begin
      state                <= next_state;
      accumulator_register <= next_accumulator;
      quotient_register    <= next_quotient;
      saved_bit            <= next_saved_bit;
      pc                   <= next_pc;
      right_half           <= next_right_half;
      word_buf             <= next_word_buf;
      pending_jump         <= next_pending_jump;
      pending_addr         <= next_pending_addr;
      resume_fetch         <= next_resume_fetch;
      store_low            <= next_store_low;
      mem_addr             <= next_mem_addr;
      mem_wdata            <= next_mem_wdata;
      foreign_order        <= next_foreign_order;
    end
  end

  // Memory requests hold steady until acknowledged.
  assign o_mem_req       = state == ST_FETCH || state == ST_STORE_READ || state == ST_STORE_WRITE;
  assign o_mem.write     = state == ST_STORE_WRITE;
  assign o_mem.address   = mem_addr;
  assign o_mem.data      = mem_wdata;
  assign o_tape_ready    = state == ST_TAPE;
  assign o_foreign_valid = state == ST_FOREIGN;
  assign o_foreign_order = foreign_order;
  assign o_accumulator   = accumulator_register;
  assign o_quotient      = quotient_register;
  assign o_halted        = state == ST_HALTED;
  assign o_location      = pc;
  assign o_right_half    = right_half;

endmodule

`default_nettype wire

// File: ose_core_checker.sv
`timescale 1ns/1ns
`default_nettype none

module ose_core_checker (
  // Clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_reset_n,
  // Watched ports
  input wire logic                     o_halted,
  input wire logic                     o_mem_req,
  input wire ose_pkg::ose_mem_req_type o_mem,
  input wire logic                     i_mem_ack,
  input wire logic [39:0]              i_mem_rdata,
  input wire logic                     i_tape_valid,
  input wire logic [39:0]              i_tape_data,
  input wire logic                     o_tape_ready,
  input wire logic                     o_print_valid,
  input wire logic                     i_print_ready,
  input wire logic [39:0]              o_print_data,
  input wire logic                     o_foreign_valid,
  input wire ose_pkg::ose_order_type   o_foreign_order,
  input wire logic                     i_foreign_done,
  input wire logic [39:0]              o_accumulator,
  input wire logic [39:0]              o_quotient
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic [39:0] last_rd;

  // A partial store merges into the last word read before its write.
  always_ff @(posedge i_clk) begin
    if (i_mem_ack && !o_mem.write) last_rd <= i_mem_rdata;
  end
  wire [39:0] mid_merge = (last_rd & ~ose_pkg::MID_FIELD_MASK) | (o_accumulator & ose_pkg::MID_FIELD_MASK);
  wire [39:0] low_merge = (last_rd & ~ose_pkg::LOW_FIELD_MASK) | (o_accumulator & ose_pkg::LOW_FIELD_MASK);

  chk_store_merge: assert property (
    o_mem_req && o_mem.write |-> o_mem.data == mid_merge || o_mem.data == low_merge)
    else $error("store not a field merge");
  chk_store_acc_kept: assert property (
    o_mem_req && o_mem.write |=> o_accumulator == $past(o_accumulator))
    else $error("store changed acc");
  chk_tape_load: assert property (
    o_tape_ready && i_tape_valid |=> o_accumulator == $past(i_tape_data) && !o_tape_ready)
    else $error("tape word not loaded");
  chk_print_word: assert property (
    $rose(o_print_valid) |-> o_print_data == o_quotient)
    else $error("print word not quotient");
  chk_print_hold: assert property (
    o_print_valid && !i_print_ready |=> o_print_valid && $stable(o_print_data))
    else $error("print word not held");
  chk_foreign_hold: assert property (
    o_foreign_valid && !i_foreign_done |=> o_foreign_valid && $stable(o_foreign_order))
    else $error("foreign order not held");
  chk_halt_quiet: assert property (
    o_halted && $past(o_halted) |-> !o_mem_req && !o_foreign_valid)
    else $error("activity while halted");
  chk_mem_hold: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem))
    else $error("memory request not held");
endmodule

bind ose_core ose_core_checker u_ose_core_checker (
  .i_clk, .i_reset_n, .o_halted, .o_mem_req, .o_mem, .i_mem_ack, .i_mem_rdata, .i_tape_valid, .i_tape_data,
  .o_tape_ready, .o_print_valid, .i_print_ready, .o_print_data, .o_foreign_valid, .o_foreign_order,
  .i_foreign_done, .o_accumulator, .o_quotient
);

`default_nettype wire

// File: ose_partner.sv
`timescale 1ns/1ns
`default_nettype none

module ose_partner #(
  parameter logic [39:0] TAPE_WORD = 40'h00_0000_0001,
  parameter logic [39:0] F_ACC     = 40'h00_0000_0002,
  parameter logic [39:0] F_QUO     = 40'h00_0000_0003
) (
  // Clock, reset and pacing
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_slow,
  // Memory
  input  wire logic                        i_mem_req,
  input  wire ose_pkg::ose_mem_req_type    i_mem,
  output logic                             o_mem_ack,
  output logic [39:0]                      o_mem_rdata,
  // Tape and printer
  output logic                             o_tape_valid,
  output logic [39:0]                      o_tape_data,
  input  wire logic                        i_print_valid,
  output logic                             o_print_ready,
  input  wire logic [39:0]                 i_print_data,
  output logic [39:0]                      o_print_last,
  // Orders outside the subset
  input  wire logic                        i_foreign_valid,
  output logic                             o_foreign_done,
  output ose_pkg::ose_foreign_result_type  o_foreign_result
);
  logic [39:0] mem [0:63];
  logic [2:0]  mcnt;
  logic [2:0]  fcnt;
  logic        tog;
  wire  [2:0]  wait_len = i_slow ? 3'h3 : 3'h0;

  // Between acks the read bus shows the inverse word, never a stale copy.
  assign o_mem_rdata = o_mem_ack ? mem[i_mem.address[5:0]] : ~mem[i_mem.address[5:0]];
  assign o_tape_valid = !i_slow || tog;
  assign o_tape_data = o_tape_valid ? TAPE_WORD : ~TAPE_WORD;
  assign o_print_ready = !i_slow || tog;
  assign o_foreign_result = '{F_ACC, F_QUO, 1'b1, 1'b0, 1'b0, 12'h000};

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mcnt <= 3'h0;
      fcnt <= 3'h0;
      tog <= 1'b0;
      o_mem_ack <= 1'b0;
      o_foreign_done <= 1'b0;
      o_print_last <= 40'h00_0000_0000;
    end else begin
      tog <= ~tog;
      if (o_mem_ack && i_mem.write) mem[i_mem.address[5:0]] <= i_mem.data;
      o_mem_ack <= 1'b0;
      o_foreign_done <= 1'b0;
      if (i_mem_req && !o_mem_ack) begin
        mcnt <= (mcnt == wait_len) ? 3'h0 : mcnt + 3'h1;
        o_mem_ack <= (mcnt == wait_len);
      end
      if (i_foreign_valid && !o_foreign_done) begin
        fcnt <= (fcnt == wait_len) ? 3'h0 : fcnt + 3'h1;
        o_foreign_done <= (fcnt == wait_len);
      end
      if (i_print_valid && o_print_ready) begin
        o_print_last <= i_print_data;
      end
    end
  end
endmodule

`default_nettype wire

// File: test_order_subset_execution.sv
`timescale 1ns/1ns
`default_nettype none

module test_order_subset_execution;
  localparam logic [39:0] TAPE = 40'h12_3456_789a;
  localparam logic [39:0] FA   = 40'h9b_cdef_0123;
  localparam logic [39:0] FQ   = 40'ha5_5a5a_5a5b;
  localparam logic [39:0] INIT = 40'hff_ffff_ffff;
  localparam logic [39:0] MID  = ose_pkg::MID_FIELD_MASK;
  localparam logic [39:0] LOW  = ose_pkg::LOW_FIELD_MASK;
  localparam logic [39:0] A1   = {FA[38:0], FQ[38]};
  localparam logic [39:0] Q1   = {FQ[39], FQ[37:0], 1'b1};
  localparam logic [39:0] A2   = {ose_pkg::SEED_VALUE[38:0], Q1[38]};
  localparam logic [39:0] Q2   = {Q1[39], Q1[37:0], 1'b1};

  logic                            clk = 1'b0;
  logic                            reset_n = 1'b0;
  logic                            start = 1'b0;
  logic                            bypass = 1'b0;
  logic                            slow = 1'b0;
  logic                            halted, mem_req, mem_ack, tape_valid, tape_ready, rh;
  logic                            print_valid, print_ready, f_valid, f_done;
  logic [11:0]                     loc;
  logic [39:0]                     rdata, tape_data, print_data, print_last, acc, quo;
  ose_pkg::ose_mem_req_type        mem;
  ose_pkg::ose_order_type          f_order;
  ose_pkg::ose_foreign_result_type f_result;
  int                              err_total = 0;
  int                              tests_run = 0;

  always #5 clk = ~clk;

  ose_core u_ose_core (
    .i_clk(clk), .i_reset_n(reset_n), .i_start_pin(start), .i_bypass_pin(bypass), .o_halted(halted),
    .o_location(loc), .o_right_half(rh), .o_mem_req(mem_req), .o_mem(mem), .i_mem_ack(mem_ack),
    .i_mem_rdata(rdata), .i_tape_valid(tape_valid), .i_tape_data(tape_data), .o_tape_ready(tape_ready),
    .o_print_valid(print_valid), .i_print_ready(print_ready), .o_print_data(print_data),
    .o_foreign_valid(f_valid), .o_foreign_order(f_order), .o_accumulator(acc), .o_quotient(quo),
    .i_foreign_done(f_done), .i_foreign_result(f_result)
  );

  ose_partner #(.TAPE_WORD(TAPE), .F_ACC(FA), .F_QUO(FQ)) u_ose_partner (
    .i_clk(clk), .i_reset_n(reset_n), .i_slow(slow), .i_mem_req(mem_req), .i_mem(mem),
    .o_mem_ack(mem_ack), .o_mem_rdata(rdata), .o_tape_valid(tape_valid), .o_tape_data(tape_data),
    .i_print_valid(print_valid), .o_print_ready(print_ready), .i_print_data(print_data),
    .o_print_last(print_last), .i_foreign_valid(f_valid), .o_foreign_done(f_done),
    .o_foreign_result(f_result)
  );

  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic ld(input int idx, input logic [7:0] lop, input logic [11:0] la,
                    input logic [7:0] rop, input logic [11:0] ra);
    u_ose_partner.mem[idx] = {lop, la, rop, ra};
  endtask

  task automatic run_to_halt;
    int n;
    n = 0;
    @(negedge clk) start = 1'b1;
    @(negedge clk iff halted === 1'b0) start = 1'b0;
    while (halted !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(40'(n >= 3000), 40'h00_0000_0000, "halt reached");
  endtask

  task automatic test_first_leg;
    run_to_halt();
    repeat (4) @(negedge clk);
    check(u_ose_partner.mem[32], (INIT & ~MID) | (TAPE & MID), "mid store");
    check(u_ose_partner.mem[33], (INIT & ~LOW) | (TAPE & LOW), "low store");
    check(u_ose_partner.mem[35], INIT & ~MID, "clear mid store");
    check(print_last, FQ, "printed word");
    check(acc, A1, "shift acc");
    check(quo, Q1, "shift quo");
  endtask

  task automatic test_halts;
    @(negedge clk) slow = 1'b1;
    run_to_halt();
    check(u_ose_partner.mem[34], INIT, "right halt");
    run_to_halt();
    check(u_ose_partner.mem[34], INIT, "left halt");
    run_to_halt();
    check(u_ose_partner.mem[34], INIT & ~LOW, "after restart");
    check(u_ose_partner.mem[36], (INIT & ~LOW) | (A2 & LOW), "jump store");
    check(acc, A2, "seeded acc");
    check(quo, Q2, "seeded quo");
  endtask

  task automatic test_bypass;
    @(negedge clk) bypass = 1'b1;
    repeat (4) @(negedge clk);
    run_to_halt();
    check(u_ose_partner.mem[37], INIT & ~LOW, "bypass store");
    check(acc, {39'h0, Q2[38]}, "clear jump acc");
    check(40'({loc, rh}), 40'h00_0000_0015, "stop place");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 64; i++) u_ose_partner.mem[i] = INIT;
    ld(0, ose_pkg::OP_IO, ose_pkg::IO_READ_ADDR, ose_pkg::OP_MID_STORE, 12'h020);
    ld(1, ose_pkg::OP_LOW_STORE, 12'h021, ose_pkg::OP_CLR_MID_STORE, 12'h023);
    ld(2, 8'h01, 12'h000, 8'h01, 12'h000);
    ld(3, ose_pkg::OP_IO, ose_pkg::IO_PRINT_ADDR, ose_pkg::OP_SLS, 12'h000);
    ld(4, ose_pkg::OP_PLAIN_HALT, 12'h000, ose_pkg::OP_HALT_XFER, 12'h006);
    ld(6, ose_pkg::OP_HALT_XFER, 12'h008, ose_pkg::OP_CLR_LOW_STORE, 12'h022);
    ld(8, ose_pkg::OP_SEED_SJ, 12'h00a, ose_pkg::OP_LOW_STORE, 12'h024);
    ld(10, ose_pkg::OP_PLAIN_HALT, 12'h000, ose_pkg::OP_HALT_XFER, 12'h00c);
    ld(12, ose_pkg::OP_CLR_SJ, 12'h00a, ose_pkg::OP_LOW_STORE, 12'h025);
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    test_first_leg();
    test_halts();
    test_bypass();
    stop_test();
  end

  // Far past the 150 or so cycles the program needs.
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule

`default_nettype wire
